// *** common/sensor_cmd_defs.vh ***
// Constants for the sensor command interpreter: timing, command codes, status layout, checksum.
// Assumes a single 40 MHz system clock; included by bare name from the design files.
`ifndef SENSOR_CMD_DEFS_VH
`define SENSOR_CMD_DEFS_VH

`define CLK_FREQ_MHZ       16'd40
`define HW_RST_MIN_NS      16'd1000
`define HW_RST_MIN_CYC     ((`HW_RST_MIN_NS * `CLK_FREQ_MHZ + 16'd999) / 16'd1000)
`define RESET_BUSY_NS      16'd1000
`define RESET_BUSY_CYC     ((`RESET_BUSY_NS * `CLK_FREQ_MHZ + 16'd999) / 16'd1000)
`define RECOVER_MIN_CLKS   4'd9

`define DEV_ADDR_DEFAULT   7'h40
`define GC_ADDR            7'h00
`define GC_RESET_BYTE      8'h06
`define CMD_HEATER_ON      16'h306d
`define CMD_HEATER_OFF     16'h3066
`define CMD_CLEAR_STATUS   16'h3041
`define CMD_READ_STATUS    16'hf000

`define CRC_POLY           8'h31
`define CRC_INIT           8'hff

`define STAT_ALERT_BIT     15
`define STAT_HEATER_BIT    13
`define STAT_RH_BIT        11
`define STAT_T_BIT         10
`define STAT_RESET_BIT     4
`define STAT_CMDERR_BIT    1
`define STAT_WCRC_BIT      0
`define STAT_ALERT_RST     1'b1
`define STAT_RESET_RST     1'b1

`endif

// *** verilog/crc8_step.v ***
// One byte step of the CRC-8 used on every data word (MSB first, no reflection).
// Purely combinational; the caller holds the running value.
`include "sensor_cmd_defs.vh"

module crc8_step (
  input  wire [7:0] crc_in,
  input  wire [7:0] data_in,
  output reg  [7:0] crc_out
);

  integer i;
  reg [7:0] c;

  always @* begin
    c = crc_in ^ data_in;
    for (i = 0; i < 8; i = i + 1) begin
      if (c[7])
        c = {c[6:0], 1'b0} ^ `CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    crc_out = c;
  end

endmodule // crc8_step

// *** verilog/sensor_cmd_ctrl.v ***
// Command interpreter of the sensor: I2C slave, resets, heater control, status word, CRC-8.
// Assumes SCL and SDA are open-drain bus lines from outside the clock domain, sampled by CLK_IN.
`include "sensor_cmd_defs.vh"

module sensor_cmd_ctrl #(
  parameter [6:0]  DEV_ADDR       = `DEV_ADDR_DEFAULT,
  parameter [15:0] HW_RST_MIN_CYC = `HW_RST_MIN_CYC,
  parameter [15:0] RESET_BUSY_CYC = `RESET_BUSY_CYC
) (
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire        HW_RESET_LOW_IN,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  input  wire        RH_ALERT_IN,
  input  wire        T_ALERT_IN,
  input  wire        SUPPLY_FAIL_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE_OUT,
  output wire        HEATER_ON_OUT,
  output wire [15:0] STATUS_OUT,
  output wire        RESET_BUSY_OUT
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_WR   = 3'd2;
  localparam [2:0] ST_RD   = 3'd3;
  localparam [2:0] ST_ACK  = 3'd4;
  localparam [2:0] ST_HACK = 3'd5;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and bus conditions
  reg scl_s1_ff, scl_s2_ff, scl_d_ff;
  reg sda_s1_ff, sda_s2_ff, sda_d_ff;
  reg rstp_s1_ff, rstp_s2_ff;

  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      scl_s1_ff  <= 1'b1;
      scl_s2_ff  <= 1'b1;
      scl_d_ff   <= 1'b1;
      sda_s1_ff  <= 1'b1;
      sda_s2_ff  <= 1'b1;
      sda_d_ff   <= 1'b1;
      rstp_s1_ff <= 1'b1;
      rstp_s2_ff <= 1'b1;
    end else begin
      scl_s1_ff  <= SCL_IN;
      scl_s2_ff  <= scl_s1_ff;
      scl_d_ff   <= scl_s2_ff;
      sda_s1_ff  <= SDA_IN;
      sda_s2_ff  <= sda_s1_ff;
      sda_d_ff   <= sda_s2_ff;
      rstp_s1_ff <= HW_RESET_LOW_IN;
      rstp_s2_ff <= rstp_s1_ff;
    end
  end

  wire scl_rise = scl_s2_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s2_ff & scl_d_ff;
  wire bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  wire bus_stop  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources and reset-in-progress window
  reg  [15:0] low_cnt_ff;
  reg  [15:0] busy_cnt_ff;
  reg         gc_rst_ff;
  wire        pin_rst = ~rstp_s2_ff && (low_cnt_ff == HW_RST_MIN_CYC - 16'd1);
  wire        rst_req = pin_rst | gc_rst_ff;
  wire        busy    = (busy_cnt_ff != 16'h0000) | (low_cnt_ff == HW_RST_MIN_CYC);

  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      low_cnt_ff  <= 16'h0000;
      busy_cnt_ff <= 16'h0000;
    end else begin
      if (rstp_s2_ff)
        low_cnt_ff <= 16'h0000;
      else if (low_cnt_ff != HW_RST_MIN_CYC)
        low_cnt_ff <= low_cnt_ff + 16'h0001;
      if (rst_req)
        busy_cnt_ff <= RESET_BUSY_CYC;
      else if (busy_cnt_ff != 16'h0000)
        busy_cnt_ff <= busy_cnt_ff - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and heater
  reg  alert_ff, heater_ff, rh_ff, t_ff, rst_det_ff, cmd_err_ff, wcrc_err_ff;
  reg  stat_rd_ff;
  reg  [15:0] cmd_ff;
  reg  crc_ok_ff;
  reg  wr_ff, gc_ff, rd_ff;
  reg  [2:0] byte_cnt_ff;
  reg  [3:0] recover_cnt_ff;
  // A recovery burst before the start must not execute the cut command
  wire wr_end   = (bus_stop | bus_start) & wr_ff & ~gc_ff & ~busy &
                  (recover_cnt_ff < `RECOVER_MIN_CLKS);
  wire cmd_two  = (byte_cnt_ff == 3'd2);
  wire cmd_five = (byte_cnt_ff == 3'd5);
  wire known    = (cmd_ff == `CMD_HEATER_ON) | (cmd_ff == `CMD_HEATER_OFF) |
                  (cmd_ff == `CMD_CLEAR_STATUS) | (cmd_ff == `CMD_READ_STATUS);
  wire clr_stat = wr_end & cmd_two & (cmd_ff == `CMD_CLEAR_STATUS);

  wire [15:0] status_word = {alert_ff, 1'b0, heater_ff, 1'b0, rh_ff, t_ff, 5'b00000,
                             rst_det_ff, 2'b00, cmd_err_ff, wcrc_err_ff};

  always @(posedge CLK_IN) begin
    if (!RST_N_IN || rst_req) begin
      alert_ff    <= `STAT_ALERT_RST;
      heater_ff   <= 1'b0;
      rh_ff       <= 1'b0;
      t_ff        <= 1'b0;
      rst_det_ff  <= `STAT_RESET_RST;
      cmd_err_ff  <= 1'b0;
      wcrc_err_ff <= 1'b0;
      stat_rd_ff  <= 1'b0;
    end else begin
      // Alert and reset events win over a clear in the same cycle
      alert_ff   <= (alert_ff & ~clr_stat) | RH_ALERT_IN | T_ALERT_IN;
      rh_ff      <= (rh_ff & ~clr_stat) | RH_ALERT_IN;
      t_ff       <= (t_ff & ~clr_stat) | T_ALERT_IN;
      rst_det_ff <= (rst_det_ff & ~clr_stat) | SUPPLY_FAIL_IN;
      if (wr_end) begin
        cmd_err_ff <= ~(cmd_two & known);
        stat_rd_ff <= cmd_two & (cmd_ff == `CMD_READ_STATUS);
        if (cmd_five)
          wcrc_err_ff <= ~crc_ok_ff;
        if (cmd_two && cmd_ff == `CMD_HEATER_ON)
          heater_ff <= 1'b1;
        if (cmd_two && cmd_ff == `CMD_HEATER_OFF)
          heater_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksums: running value on write data, fixed pair on the status read
  reg  [7:0]  shift_ff;
  reg  [7:0]  rx_crc_ff;
  reg  [15:0] snap_ff;
  wire [7:0]  rx_seed = (byte_cnt_ff == 3'd2) ? `CRC_INIT : rx_crc_ff;
  wire [7:0]  rx_crc_nxt;
  wire [7:0]  tx_crc_msb;
  wire [7:0]  tx_crc;

  crc8_step u_rx_crc  (.crc_in(rx_seed),    .data_in(shift_ff),      .crc_out(rx_crc_nxt));
  crc8_step u_tx_crc0 (.crc_in(`CRC_INIT),  .data_in(snap_ff[15:8]), .crc_out(tx_crc_msb));
  crc8_step u_tx_crc1 (.crc_in(tx_crc_msb), .data_in(snap_ff[7:0]),  .crc_out(tx_crc));

  function [7:0] tx_pick;
    input [1:0]  idx;
    input [15:0] word;
    input [7:0]  crc;
    begin
      case (idx)
        2'd0:    tx_pick = word[15:8];
        2'd1:    tx_pick = word[7:0];
        default: tx_pick = crc;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave engine
  reg  [2:0] state_ff;
  reg  [3:0] bit_cnt_ff;
  reg  [1:0] tx_idx_ff;
  reg        sda_oe_ff;
  reg        host_nack_ff;
  wire [7:0] tx_cur  = tx_pick(tx_idx_ff, snap_ff, tx_crc) << bit_cnt_ff;
  wire [7:0] tx_next = tx_pick(tx_idx_ff + 2'd1, snap_ff, tx_crc);
  wire       addr_me = (shift_ff[7:1] == DEV_ADDR);
  wire       addr_gc = (shift_ff[7:1] == `GC_ADDR) & ~shift_ff[0];

  always @(posedge CLK_IN) begin
    if (!RST_N_IN || busy) begin
      state_ff       <= ST_IDLE;
      bit_cnt_ff     <= 4'h0;
      byte_cnt_ff    <= 3'd0;
      tx_idx_ff      <= 2'd0;
      sda_oe_ff      <= 1'b0;
      shift_ff       <= 8'h00;
      cmd_ff         <= 16'h0000;
      rx_crc_ff      <= `CRC_INIT;
      crc_ok_ff      <= 1'b0;
      snap_ff        <= 16'h0000;
      wr_ff          <= 1'b0;
      gc_ff          <= 1'b0;
      rd_ff          <= 1'b0;
      gc_rst_ff      <= 1'b0;
      host_nack_ff   <= 1'b0;
      recover_cnt_ff <= 4'h0;
    end else begin
      gc_rst_ff <= 1'b0;
      // Our own acknowledge during the burst still counts as a released line
      if (scl_rise && (sda_s2_ff || sda_oe_ff) && recover_cnt_ff != 4'hf)
        recover_cnt_ff <= recover_cnt_ff + 4'h1;
      else if (scl_rise)
        recover_cnt_ff <= 4'h0;
      if (bus_start) begin
        // A start restarts the interface unless a reset is in progress; after a recovery burst only the interface is touched
        state_ff       <= ST_ADDR;
        bit_cnt_ff     <= 4'h0;
        byte_cnt_ff    <= 3'd0;
        sda_oe_ff      <= 1'b0;
        wr_ff          <= 1'b0;
        gc_ff          <= 1'b0;
        rd_ff          <= 1'b0;
        recover_cnt_ff <= 4'h0;
      end else if (bus_stop) begin
        state_ff  <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        wr_ff     <= 1'b0;
        gc_ff     <= 1'b0;
        rd_ff     <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_ff   <= {shift_ff[6:0], sda_s2_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              if (state_ff == ST_ADDR) begin
                if (addr_me && !shift_ff[0]) begin
                  wr_ff     <= 1'b1;
                  sda_oe_ff <= 1'b1;
                  state_ff  <= ST_ACK;
                end else if (addr_me && stat_rd_ff) begin
                  rd_ff     <= 1'b1;
                  snap_ff   <= status_word;
                  tx_idx_ff <= 2'd0;
                  sda_oe_ff <= 1'b1;
                  state_ff  <= ST_ACK;
                end else if (addr_gc) begin
                  gc_ff     <= 1'b1;
                  sda_oe_ff <= 1'b1;
                  state_ff  <= ST_ACK;
                end else begin
                  state_ff <= ST_IDLE;
                end
              end else begin
                sda_oe_ff <= 1'b1;
                state_ff  <= ST_ACK;
                if (byte_cnt_ff != 3'd7)
                  byte_cnt_ff <= byte_cnt_ff + 3'd1;
                if (gc_ff && byte_cnt_ff == 3'd0 && shift_ff == `GC_RESET_BYTE)
                  gc_rst_ff <= 1'b1;
                if (byte_cnt_ff == 3'd0)
                  cmd_ff[15:8] <= shift_ff;
                if (byte_cnt_ff == 3'd1)
                  cmd_ff[7:0] <= shift_ff;
                if (byte_cnt_ff == 3'd2 || byte_cnt_ff == 3'd3)
                  rx_crc_ff <= rx_crc_nxt;
                if (byte_cnt_ff == 3'd4)
                  crc_ok_ff <= (shift_ff == rx_crc_ff);
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_ff) begin
                sda_oe_ff  <= ~tx_cur[7];
                bit_cnt_ff <= 4'h1;
                state_ff   <= ST_RD;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff  <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                sda_oe_ff  <= 1'b0;
                bit_cnt_ff <= 4'h0;
                state_ff   <= ST_HACK;
              end else begin
                sda_oe_ff  <= ~tx_cur[7];
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          ST_HACK: begin
            if (scl_rise)
              host_nack_ff <= sda_s2_ff;
            else if (scl_fall) begin
              if (!host_nack_ff && tx_idx_ff != 2'd2) begin
                tx_idx_ff  <= tx_idx_ff + 2'd1;
                sda_oe_ff  <= ~tx_next[7];
                bit_cnt_ff <= 4'h1;
                state_ff   <= ST_RD;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          default: begin
            state_ff  <= ST_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign SDA_OUT        = 1'b0;
  assign SDA_OE_OUT     = sda_oe_ff;
  assign HEATER_ON_OUT  = heater_ff;
  assign STATUS_OUT     = status_word;
  assign RESET_BUSY_OUT = busy;

endmodule // sensor_cmd_ctrl

// *** bench/sensor_cmd_ctrl_sva.sv ***
// Assertions on the ports of the sensor command interpreter.
// Assumes one CLK_IN domain with synchronous active-low RST_N_IN; bound below.
module sensor_cmd_ctrl_sva #(
  parameter [15:0] HW_RST_MIN_CYC = 16'd40,
  parameter [15:0] RESET_BUSY_CYC = 16'd40
) (
  input wire        CLK_IN,
  input wire        RST_N_IN,
  input wire        HW_RESET_LOW_IN,
  input wire        SCL_IN,
  input wire        SDA_IN,
  input wire        RH_ALERT_IN,
  input wire        T_ALERT_IN,
  input wire        SUPPLY_FAIL_IN,
  input wire        SDA_OUT,
  input wire        SDA_OE_OUT,
  input wire        HEATER_ON_OUT,
  input wire [15:0] STATUS_OUT,
  input wire        RESET_BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////////////
  rst_val_a: assert property (!$past(RST_N_IN) |-> STATUS_OUT == 16'h8010 && !HEATER_ON_OUT)
    else $error("status not at reset value");
  heat_bit_a: assert property (STATUS_OUT[13] == HEATER_ON_OUT)
    else $error("heater bit differs from heater");
  rsvd_zero_a: assert property ({STATUS_OUT[14], STATUS_OUT[12], STATUS_OUT[3:2]} == 4'h0)
    else $error("reserved status bit set");
  rh_alert_a: assert property (RH_ALERT_IN && !RESET_BUSY_OUT |=> STATUS_OUT[15] && STATUS_OUT[11])
    else $error("humidity alert not recorded");
  t_alert_a: assert property (T_ALERT_IN && !RESET_BUSY_OUT |=> STATUS_OUT[15] && STATUS_OUT[10])
    else $error("temperature alert not recorded");
  supply_flag_a: assert property (SUPPLY_FAIL_IN && !RESET_BUSY_OUT |=> STATUS_OUT[4])
    else $error("supply failure not recorded");
  clear_at_end_a: assert property ($fell(STATUS_OUT[4]) |-> SCL_IN)
    else $error("reset flag cleared mid transfer");
  heat_change_a: assert property ($changed(HEATER_ON_OUT) |-> SCL_IN || RESET_BUSY_OUT)
    else $error("heater changed mid transfer");
  busy_quiet_a: assert property (RESET_BUSY_OUT && $past(RESET_BUSY_OUT, 2) |-> !SDA_OE_OUT)
    else $error("bus driven during reset");
  busy_len_a: assert property ($rose(RESET_BUSY_OUT) |-> RESET_BUSY_OUT [*8])
    else $error("reset procedure too short");
endmodule // sensor_cmd_ctrl_sva

bind sensor_cmd_ctrl sensor_cmd_ctrl_sva #(.HW_RST_MIN_CYC(HW_RST_MIN_CYC), .RESET_BUSY_CYC(RESET_BUSY_CYC)) chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .HW_RESET_LOW_IN(HW_RESET_LOW_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .RH_ALERT_IN(RH_ALERT_IN), .T_ALERT_IN(T_ALERT_IN), .SUPPLY_FAIL_IN(SUPPLY_FAIL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT), .HEATER_ON_OUT(HEATER_ON_OUT), .STATUS_OUT(STATUS_OUT), .RESET_BUSY_OUT(RESET_BUSY_OUT));

// *** bench/i2c_host_model.sv ***
// Host side of the two-wire bus: drives SCL and its half of SDA, 200 ns per bit.
// Assumes a pull-up on SDA and tasks entered at a falling clk edge.
module i2c_host_model (
  input  wire  clk,
  input  wire  dev_sda,
  input  wire  dev_oe,
  output logic scl,
  output wire  sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b1;
  initial scl = 1'b1;
  // Pull-up wins unless a party pulls low
  assign sda = drv & (dev_oe ? dev_sda : 1'b1);
  task hp;
    repeat (4) @(negedge clk);
  endtask
  task wbit(input logic b, output logic r);
    drv = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
  endtask
  task start;
    drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    drv = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  task stop;
    drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    drv = 1'b1;
    hp;
  endtask
  task wbyte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) wbit(b[i], r);
    wbit(1'b1, nack);
  endtask
  task rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) wbit(1'b1, b[i]);
    wbit(last, r);
  endtask
  // Nine clocks with SDA released; caller follows with a start
  task recover;
    logic r;
    repeat (9) wbit(1'b1, r);
  endtask
endmodule // i2c_host_model

// *** bench/sensor_cmd_ctrl_tb.sv ***
// Self-checking bench for the command interpreter: commands, status reads, resets, events.
// Assumes the host model drives the bus and the checker is bound to the design.
module sensor_cmd_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_n = 1'b1;
  logic        rh = 1'b0;
  logic        ta = 1'b0;
  logic        sf = 1'b0;
  wire         scl, sda, sda_o, sda_oe, heat, busy;
  wire  [15:0] stat;
  int          n_fail = 0;
  int          n_compared = 0;
  logic        nk;
  logic [7:0]  b0, b1, b2;
  i2c_host_model host (.clk(clk), .dev_sda(sda_o), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  sensor_cmd_ctrl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .HW_RESET_LOW_IN(hw_n), .SCL_IN(scl), .SDA_IN(sda),
    .RH_ALERT_IN(rh), .T_ALERT_IN(ta), .SUPPLY_FAIL_IN(sf), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
    .HEATER_ON_OUT(heat), .STATUS_OUT(stat), .RESET_BUSY_OUT(busy));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stat_is(input logic [15:0] w);
    check(stat, w);
    check({15'h0000, heat}, {15'h0000, w[13]});
  endtask
  // Address 0x40 write header is 0x80; sends the top n bytes of d
  task xfer(input logic [47:0] d, input int n);
    host.start;
    for (int i = 0; i < n; i++) host.wbyte(d[47-8*i -: 8], nk);
    host.stop;
    repeat (8) @(negedge clk);
  endtask
  task cmd(input logic [15:0] c);
    xfer({8'h80, c, 24'h000000}, 3);
  endtask
  task rd_status(input logic [15:0] w);
    cmd(16'hf000);
    host.start;
    host.wbyte(8'h81, nk);
    check({15'h0000, nk}, 16'h0000);
    host.rbyte(1'b0, b0);
    host.rbyte(1'b0, b1);
    host.rbyte(1'b1, b2);
    host.stop;
    check({b0, b1}, w);
    check({8'h00, b2}, {8'h00, crc8(w)});
  endtask
  task pulse(input int k);
    {rh, ta, sf} = 3'b100 >> k;
    @(negedge clk);
    {rh, ta, sf} = 3'b000;
    repeat (2) @(negedge clk);
  endtask
  task settle;
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
    check({15'h0000, busy}, 16'h0000);
    repeat (4) @(negedge clk);
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    stat_is(16'h8010);
    rd_status(16'h8010);
    cmd(16'h3041);
    stat_is(16'h0000);
    cmd(16'h306d);
    rd_status(16'h2000);
    cmd(16'h3099);
    stat_is(16'h2002);
    cmd(16'h3066);
    stat_is(16'h0000);
    for (int a = 1; a < 3; a++) begin
      host.start;
      host.wbyte(8'h80 + a, nk);
      host.stop;
      check({15'h0000, nk}, 16'h0001);
    end
    done("commands");
    xfer({16'h8030, 16'h99be, 16'hef93}, 6);
    stat_is(16'h0003);
    xfer({16'h8030, 16'h99be, 16'hef92}, 6);
    stat_is(16'h0002);
    pulse(0);
    stat_is(16'h8802);
    pulse(1);
    stat_is(16'h8c02);
    cmd(16'h3041);
    stat_is(16'h0000);
    pulse(2);
    stat_is(16'h0010);
    done("checksum and events");
    cmd(16'h306d);
    pulse(0);
    host.start;
    host.wbyte(8'h80, nk);
    host.wbyte(8'h30, nk);
    host.recover;
    host.start;
    host.stop;
    repeat (8) @(negedge clk);
    stat_is(16'ha810);
    cmd(16'h306d);
    stat_is(16'ha810);
    hw_n = 1'b0;
    repeat (20) @(negedge clk);
    hw_n = 1'b1;
    repeat (8) @(negedge clk);
    stat_is(16'ha810);
    hw_n = 1'b0;
    host.start;
    host.wbyte(8'h80, nk);
    check({15'h0000, nk}, 16'h0001);
    host.stop;
    hw_n = 1'b1;
    settle;
    stat_is(16'h8010);
    cmd(16'h306d);
    xfer({16'h0006, 32'h00000000}, 2);
    settle;
    stat_is(16'h8010);
    done("resets");
    complete_run;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule // sensor_cmd_ctrl_tb
